// File: verilog/sarro_consts.svh
// Timing and format constants of the serial cascade readout.
// Assumes a 25 MHz system clock (40 ns period).
`ifndef SARRO_CONSTS_SVH
`define SARRO_CONSTS_SVH
`define SARRO_CLK_NS 40
`define SARRO_WORD_BITS 16
`define SARRO_CNT_W 5
`define SARRO_BUSY_TYP_NS 18000
`define SARRO_BUSY_MAX_NS 20000
`define SARRO_BUSY_CYC (`SARRO_BUSY_TYP_NS / `SARRO_CLK_NS)
`define SARRO_ICLK_MIN_NS 600
`define SARRO_ICLK_TYP_NS 820
`define SARRO_ICLK_MAX_NS 850
`define SARRO_ICLK_HALF_CYC ((`SARRO_ICLK_TYP_NS / `SARRO_CLK_NS) / 2)
`define SARRO_PREV_HOLD_NS 2000
`define SARRO_PREV_HOLD_CYC ((`SARRO_PREV_HOLD_NS + `SARRO_CLK_NS - 1) / `SARRO_CLK_NS)
`define SARRO_POS_FS 16'h7fff
`define SARRO_NEG_FS 16'h8000
`define SARRO_FIFO_DEPTH 8
`define SARRO_FIFO_AW 3
`endif

// File: verilog/sarro_pkg.sv
// Types of the serial cascade readout.
// Assumes sarro_consts.svh is available on the include path.
package sarro_pkg;
  typedef enum logic [1:0] {
    SARRO_IDLE,
    SARRO_CONV,
    SARRO_ISHIFT
  } sarro_state_t;
  typedef logic [15:0] sarro_word_t;
endpackage : sarro_pkg

// File: verilog/sarro_fifo.sv
// Result word FIFO between the converter core and the readout.
// Assumes both sides on one clock with synchronous active-high reset.
module sarro_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
    logic dval;
  } sarro_fifo_st_t;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  sarro_fifo_st_t st_reg;
  sarro_fifo_st_t st_next;
  logic push;
  logic pop;

  assign in_ready_o = (st_reg.cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = st_reg.dval;
  assign out_data_o = st_reg.dout;
  assign push = in_valid_i && in_ready_o;
  assign pop = (st_reg.cnt != '0) && (!st_reg.dval || out_ready_i);

  // ----------------------------------------------------------
  // Pointer and output register update
  // ----------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = st_reg.rd + AW'(1);
      st_next.dout = mem_reg[st_reg.rd];
      st_next.dval = 1'b1;
    end else if (out_ready_i) begin
      st_next.dval = 1'b0;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem_reg[st_reg.wr] <= in_data_i;
    end
  end
endmodule // sarro_fifo

// File: verilog/sarro_ext_shift.sv
// Link-side shifter running on the external serial shift clock.
// Assumes the word and its load toggle are stable across the crossing.
module sarro_ext_shift (
  input wire logic serial_shift_clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic cascade_in_i,
  input wire logic load_tgl_i,
  input sarro_pkg::sarro_word_t load_word_i,
  output logic serial_out_o,
  output logic load_ack_tgl_o
);
  import sarro_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic rst1;
    logic rst2;
    logic seen;
    logic [16:0] sh;
  } sarro_ext_st_t;

  sarro_ext_st_t st_reg;
  sarro_ext_st_t st_next;

  assign serial_out_o = st_reg.sh[16];
  assign load_ack_tgl_o = st_reg.seen;

  // ----------------------------------------------------------
  // Shift on each enabled external clock, load on toggle change
  // ----------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = load_tgl_i;
    st_next.s2 = st_reg.s1;
    st_next.rst1 = reset_i;
    st_next.rst2 = st_reg.rst1;
    if (st_reg.rst2) begin
      st_next.sh = '0;
      st_next.seen = st_reg.s2;
    end else if (st_reg.s2 != st_reg.seen) begin
      st_next.sh = {load_word_i, cascade_in_i};
      st_next.seen = st_reg.s2;
    end else if (enable_i) begin
      st_next.sh = {st_reg.sh[15:0], cascade_in_i};
    end
  end

  always_ff @(negedge serial_shift_clock_i) begin
    st_reg <= st_next;
  end
endmodule // sarro_ext_shift

// File: verilog/sarro_top.sv
// Serial result readout with cascade chaining for a sampling converter.
// Assumes a converter core delivers signed raw results with range flags.
// Summary of operation
// - Serial output feeds next cascade input; bits move with external shift clock.
// - At read end, output shows cascade level sampled at read start.
// - Single device internal mode: after 16 bits, output holds captured level.
// - Captured cascade level forms separator bit between chained words.
// - Out-of-range inputs give full-scale codes, never wrapping.
// - Busy stays low during conversion, typical 18 us, max 20 us.
// - Internal shift clock period between 600 ns and 850 ns.
// - Previous result remains readable at least 2 us after conversion start.
// - Internal mode shifts previous 16-bit result MSB first on 16 pulses.
// - Clock source select high means external clock, low means internal.
`include "sarro_consts.svh"
module sarro_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic serial_shift_clock_i,
  input wire logic ext_clock_sel_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_n_i,
  input wire logic cascade_in_i,
  input sarro_pkg::sarro_word_t core_result_i,
  input wire logic core_over_i,
  input wire logic core_under_i,
  output logic busy_n_o,
  output logic serial_shift_clock_o,
  output logic serial_shift_clock_oe_o,
  output logic serial_result_out_o,
  output logic result_ready_o
);
  import sarro_pkg::*;

  typedef struct packed {
    sarro_state_t state;
    logic [1:0] cs_sync;
    logic [1:0] rc_sync;
    logic [1:0] sel_sync;
    logic [1:0] tag_sync;
    logic [1:0] ext_sync;
    logic [1:0] ack_sync;
    logic ext_mode;
    logic conv_prev;
    logic [15:0] busy_cnt;
    logic [7:0] hold_cnt;
    logic [4:0] half_cnt;
    logic [4:0] bit_cnt;
    logic iclk;
    logic [16:0] ishift;
    logic captured_tag;
    sarro_word_t out_word;
    logic load_tgl;
    logic busy_n;
    logic prev_valid;
  } sarro_st_t;

  sarro_st_t st_reg;
  sarro_st_t st_next;
  sarro_word_t clipped;
  logic fifo_in_ready;
  logic fifo_in_valid;
  sarro_word_t fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic ext_serial;
  logic ext_ack;
  logic conv_start;
  logic ext_enable;

  // ----------------------------------------------------------
  // Saturation of the core result
  // ----------------------------------------------------------
  always_comb begin
    if (core_over_i) begin
      clipped = `SARRO_POS_FS;
    end else if (core_under_i) begin
      clipped = `SARRO_NEG_FS;
    end else begin
      clipped = core_result_i;
    end
  end

  // ----------------------------------------------------------
  // Result buffer between conversion and readout
  // ----------------------------------------------------------
  sarro_fifo #(
    .WIDTH(`SARRO_WORD_BITS),
    .DEPTH(`SARRO_FIFO_DEPTH),
    .AW(`SARRO_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_data_i(clipped),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready)
  );

  // ----------------------------------------------------------
  // External clock shifter in the link domain
  // ----------------------------------------------------------
  assign ext_enable = st_reg.ext_mode && !chip_select_n_i && read_convert_n_i;
  sarro_ext_shift u_ext (
    .serial_shift_clock_i(serial_shift_clock_i),
    .reset_i(reset_i),
    .enable_i(ext_enable),
    .cascade_in_i(cascade_in_i),
    .load_tgl_i(st_reg.load_tgl),
    .load_word_i(st_reg.out_word),
    .serial_out_o(ext_serial),
    .load_ack_tgl_o(ext_ack)
  );

  assign conv_start = !st_reg.cs_sync[1] && !st_reg.rc_sync[1];
  // Conversion end stores a word; the previous word stays held for the hold window
  assign fifo_in_valid = (st_reg.state == SARRO_CONV) && (st_reg.busy_cnt == 16'd1);
  // Internal mode has no link clock, so only external mode waits for the link acknowledge
  assign fifo_out_ready = (st_reg.hold_cnt == 8'd0) && (st_reg.state != SARRO_ISHIFT)
    && (!st_reg.ext_mode || (st_reg.load_tgl == st_reg.ack_sync[1]));

  // ----------------------------------------------------------
  // Conversion, hold and internal shift sequencing
  // ----------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.cs_sync = {st_reg.cs_sync[0], chip_select_n_i};
    st_next.rc_sync = {st_reg.rc_sync[0], read_convert_n_i};
    st_next.sel_sync = {st_reg.sel_sync[0], ext_clock_sel_i};
    st_next.tag_sync = {st_reg.tag_sync[0], cascade_in_i};
    st_next.ack_sync = {st_reg.ack_sync[0], ext_ack};
    st_next.ext_mode = st_reg.sel_sync[1];
    st_next.conv_prev = conv_start;
    if (st_reg.hold_cnt != 8'd0) begin
      st_next.hold_cnt = st_reg.hold_cnt - 8'd1;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      st_next.out_word = fifo_out_data;
      st_next.load_tgl = st_reg.ext_mode ? ~st_reg.load_tgl : st_reg.load_tgl;
      st_next.prev_valid = 1'b1;
    end
    case (st_reg.state)
      SARRO_IDLE: begin
        if (conv_start && !st_reg.conv_prev && fifo_in_ready) begin
          st_next.state = SARRO_CONV;
          st_next.busy_n = 1'b0;
          st_next.busy_cnt = 16'(`SARRO_BUSY_CYC);
          st_next.hold_cnt = 8'(`SARRO_PREV_HOLD_CYC);
          st_next.captured_tag = st_reg.tag_sync[1];
          if (!st_reg.ext_mode) begin
            st_next.ishift = {st_reg.out_word, st_reg.tag_sync[1]};
            st_next.bit_cnt = 5'(`SARRO_WORD_BITS);
            st_next.half_cnt = 5'(`SARRO_ICLK_HALF_CYC);
            st_next.iclk = 1'b0;
          end
        end
      end
      SARRO_CONV: begin
        if (!st_reg.ext_mode && st_reg.bit_cnt != 5'd0) begin
          if (st_reg.half_cnt == 5'd1) begin
            st_next.half_cnt = 5'(`SARRO_ICLK_HALF_CYC);
            st_next.iclk = ~st_reg.iclk;
            if (st_reg.iclk) begin
              st_next.bit_cnt = st_reg.bit_cnt - 5'd1;
              st_next.ishift = {st_reg.ishift[15:0], st_reg.captured_tag};
            end
          end else begin
            st_next.half_cnt = st_reg.half_cnt - 5'd1;
          end
        end
        if (st_reg.busy_cnt == 16'd1) begin
          st_next.busy_n = 1'b1;
          st_next.state = SARRO_IDLE;
          st_next.iclk = 1'b0;
        end else begin
          st_next.busy_cnt = st_reg.busy_cnt - 16'd1;
        end
      end
      default: begin
        st_next.state = SARRO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
      st_reg.busy_n <= 1'b1;
      st_reg.cs_sync <= 2'h3;
      st_reg.rc_sync <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------
  assign busy_n_o = st_reg.busy_n;
  assign serial_shift_clock_o = st_reg.iclk;
  assign serial_shift_clock_oe_o = !st_reg.ext_mode;
  assign serial_result_out_o = st_reg.ext_mode ? ext_serial : st_reg.ishift[16];
  assign result_ready_o = st_reg.prev_valid;
endmodule // sarro_top

// File: tb/sarro_host_model.sv
// Host serial port with an upstream cascade source.
// Assumes the bench calls burst for each read frame.
module sarro_host_model (
  input wire logic idle_tag_i,
  input wire logic serial_result_out_i,
  output logic serial_shift_clock_o,
  output logic cascade_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pat;
  logic act = 1'b0;
  // Upstream bits while shifting, a steady level otherwise
  assign cascade_o = act ? pat[7] : idle_tag_i;
  initial serial_shift_clock_o = 1'b0;
  // Clock only within frames, low between them; reads after busy only
  task automatic burst(input int n, input logic [7:0] p, output logic [23:0] g);
    g = '0;
    pat = p;
    act = 1'b1;
    repeat (n) begin
      serial_shift_clock_o = 1'b1;
      g = {g[22:0], serial_result_out_i};
      #15;
      serial_shift_clock_o = 1'b0;
      #5;
      pat = {pat[6:0], 1'b0};
      #10;
    end
    act = 1'b0;
  endtask
endmodule // sarro_host_model

// File: tb/sarro_top_assertions.sv
// Pin checks of the serial readout.
// Assumes a bind onto sarro_top.
module sarro_top_assertions (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ext_clock_sel_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_n_i,
  input wire logic busy_n_o,
  input wire logic serial_shift_clock_o,
  input wire logic serial_shift_clock_oe_o
);
  logic [9:0] bcnt_reg;
  logic [4:0] pcnt_reg;
  logic [4:0] hcnt_reg;
  logic sclk_reg;
  always_ff @(posedge clk_i) begin
    sclk_reg <= serial_shift_clock_o;
    hcnt_reg <= serial_shift_clock_o ? hcnt_reg + 5'h1 : 5'h0;
    bcnt_reg <= busy_n_o ? 10'h0 : bcnt_reg + 10'h1;
    pcnt_reg <= busy_n_o ? 5'h0 : pcnt_reg + 5'(serial_shift_clock_o & ~sclk_reg);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_start;
    $past(!chip_select_n_i && !read_convert_n_i);
  endsequence
  sequence s_high;
    ##9 (serial_shift_clock_o && hcnt_reg == 5'd9) ##1 !serial_shift_clock_o;
  endsequence
  property p_busy_start;
    $fell(busy_n_o) |-> s_start;
  endproperty
  property p_busy_len;
    $rose(busy_n_o) |-> bcnt_reg inside {[449:451]};
  endproperty
  property p_busy_max;
    bcnt_reg <= 10'd500;
  endproperty
  property p_iclk_half;
    $rose(serial_shift_clock_o) |-> s_high;
  endproperty
  property p_iclk_busy;
    serial_shift_clock_o |-> !busy_n_o;
  endproperty
  property p_iclk_count;
    $rose(busy_n_o) |-> pcnt_reg == (serial_shift_clock_oe_o ? 5'd16 : 5'd0);
  endproperty
  property p_ext_oe;
    ext_clock_sel_i [*6] |-> !serial_shift_clock_oe_o;
  endproperty
  property p_int_oe;
    !ext_clock_sel_i [*6] |-> serial_shift_clock_oe_o;
  endproperty
  property p_ext_quiet;
    ext_clock_sel_i [*6] |-> !serial_shift_clock_o;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy fell without start");
  a_busy_len: assert property (p_busy_len) else $error("busy low length wrong");
  a_busy_max: assert property (p_busy_max) else $error("busy low too long");
  a_iclk_half: assert property (p_iclk_half) else $error("shift clock half period wrong");
  a_iclk_busy: assert property (p_iclk_busy) else $error("shift clock outside conversion");
  a_iclk_count: assert property (p_iclk_count) else $error("shift pulse count wrong");
  a_ext_oe: assert property (p_ext_oe) else $error("clock driven in external mode");
  a_int_oe: assert property (p_int_oe) else $error("clock not driven in internal mode");
  a_ext_quiet: assert property (p_ext_quiet) else $error("clock pulses in external mode");
endmodule // sarro_top_assertions
bind sarro_top sarro_top_assertions sarro_top_assertions_i (.clk_i, .reset_i, .ext_clock_sel_i, .chip_select_n_i,
  .read_convert_n_i, .busy_n_o, .serial_shift_clock_o, .serial_shift_clock_oe_o);

// File: tb/sarro_top_test.sv
// Bench of the serial readout.
// Assumes sarro_host_model at the serial side.
module sarro_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sarro_pkg::*;
  logic clk_i, reset_i, ext_sel, cs_n, rc_n, ov, un, idle_tag, sclk, tag;
  logic busy_n, sclk_o, serial_result_out, rdy;
  sarro_word_t res, prev_word, cap;
  logic [23:0] got;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  bit have_prev = 0;
  sarro_top sarro_top_i (.clk_i(clk_i), .reset_i(reset_i), .serial_shift_clock_i(sclk), .ext_clock_sel_i(ext_sel),
    .chip_select_n_i(cs_n), .read_convert_n_i(rc_n), .cascade_in_i(tag), .core_result_i(res), .core_over_i(ov),
    .core_under_i(un), .busy_n_o(busy_n), .serial_shift_clock_o(sclk_o), .serial_shift_clock_oe_o(),
    .serial_result_out_o(serial_result_out), .result_ready_o(rdy));
  sarro_host_model sarro_host_model_i (.idle_tag_i(idle_tag), .serial_result_out_i(serial_result_out),
    .serial_shift_clock_o(sclk), .cascade_o(tag));
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  function automatic sarro_word_t exp_word(sarro_word_t r, logic o, logic u);
    return o ? 16'h7fff : (u ? 16'h8000 : r);
  endfunction
  task automatic check(string n, sarro_word_t e, sarro_word_t g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic conv(logic e, logic o, logic u, logic c);
    logic l;
    logic [7:0] p;
    ext_sel = e;
    res = 16'($urandom);
    ov = o;
    un = u;
    idle_tag = c;
    cs_n = 0;
    step(10);
    rc_n = 0;
    step(10);
    check("busy", 16'h0, 16'(busy_n));
    rc_n = 1;
    l = 0;
    cap = 0;
    for (int i = 0; i < 600 && busy_n !== 1'b1; i++) begin
      rc_n = !(i >= 100 && i < 105);
      if (sclk_o === 1'b1 && l === 1'b0) cap = {cap[14:0], serial_result_out};
      l = sclk_o;
      step(1);
    end
    check("busy_end", 16'h1, 16'(busy_n));
    if (!e && have_prev) check("int_word", prev_word, cap);
    if (!e) check("int_tail", 16'(c), 16'(serial_result_out));
    prev_word = exp_word(res, o, u);
    have_prev = 1;
    step(80);
    check("ready", 16'h1, 16'(rdy));
    if (e) begin
      p = 8'($urandom);
      cs_n = 1;
      step(4);
      sarro_host_model_i.burst(3, {8{c}}, got);
      cs_n = 0;
      step(6);
      sarro_host_model_i.burst(24, p, got);
      check("ext_word", prev_word, got[23:8]);
      check("ext_tag", 16'({c, p[7:1]}), 16'(got[7:0]));
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 12000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    reset_i = 1;
    ext_sel = 0;
    cs_n = 1;
    rc_n = 1;
    res = 0;
    ov = 0;
    un = 0;
    idle_tag = 0;
    void'($urandom(32'hc8ad));
    fork
      sarro_host_model_i.burst(4, 8'h0, got);
    join_none
    step(20);
    reset_i = 0;
    step(4);
    check("ready", 16'h0, 16'(rdy));
    for (int k = 0; k < 10; k++) begin
      conv(k % 3 == 2, k == 0 || k == 8, k == 3, 1'($urandom));
    end
    print_verdict();
  end
endmodule // sarro_top_test
